/* File: hw/bsog_gate.sv */
// Boot security option gate with Avalon-MM registers and response timing.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "bsog_map.svh"
module bsog_gate #(
    parameter logic [20:0] CKSUM_FLASH_GEAR = 21'(`BSOG_T_CKSUM_FLASH)
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [15:0] flash_addr_o,
    output logic flash_rd_o,
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_rvalid_i,
    input wire logic sec_nv_i,
    output logic grant_o,
    output logic err_o,
    output logic resp_o,
    output logic idle_o,
    output logic sec_en_o
);
    localparam int GEAR_DIV = `BSOG_CORE_MHZ / `BSOG_GEAR_MHZ;

    bsog_pkg::bsog_state_t state;
    bsog_pkg::bsog_cmd_t cmd;
    bsog_pkg::bsog_err_t err_code;
    bsog_pkg::bsog_err_t next_err;
    logic next_pass;
    logic [7:0] erase_skip;
    logic [7:0] debug_skip;
    logic blank;
    logic init_done;
    logic sec_pending;
    logic [2:0] gear_cnt;
    logic gear_tick;
    logic tmr_busy;
    logic tmr_done;
    logic tmr_start;
    logic [20:0] tmr_load;
    logic wr_fire;
    logic cmd_wr;
    logic evt_wr;
    logic is_erase;
    logic secset_go;

    // The gear clock is a one-cycle enable divided from the core clock.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gear_cnt <= 3'h0;
            gear_tick <= 1'b0;
        end else if (gear_cnt == 3'(GEAR_DIV - 1)) begin
            gear_cnt <= 3'h0;
            gear_tick <= 1'b1;
        end else begin
            gear_cnt <= gear_cnt + 3'h1;
            gear_tick <= 1'b0;
        end
    end

    // Each bus request is answered at the second edge after it appears.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
        end
    end

    assign wr_fire = avs_write_i && !avs_waitrequest_o;
    assign cmd_wr = wr_fire && (avs_address_i == `BSOG_REG_CMD) &&
        (avs_byteenable_i[1:0] == 2'h3);
    assign evt_wr = wr_fire && (avs_address_i == `BSOG_REG_EVT) && avs_byteenable_i[0];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                `BSOG_REG_CMD: avs_readdata_o <= {19'h00000, cmd};
                `BSOG_REG_STATUS: avs_readdata_o <= {24'h000000, err_code, blank,
                    sec_en_o, tmr_busy, state != bsog_pkg::BSOG_ST_READY, idle_o};
                `BSOG_REG_OPT: avs_readdata_o <= {16'h0000, debug_skip, erase_skip};
                default: avs_readdata_o <= 32'h00000000;
            endcase
        end
    end

    // A new command is taken only while ready; idle refuses commands and event writes but still answers reads.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd <= '0;
        end else if (cmd_wr && state == bsog_pkg::BSOG_ST_READY) begin
            cmd <= bsog_pkg::bsog_cmd_t'(avs_writedata_i[12:0]);
        end
    end

    // Both option bytes and the blank window are re-read for every command.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= bsog_pkg::BSOG_ST_READY;
            flash_addr_o <= 16'h0000;
            flash_rd_o <= 1'b0;
        end else begin
            flash_rd_o <= 1'b0;
            case (state)
                bsog_pkg::BSOG_ST_READY: begin
                    if (cmd_wr) begin
                        flash_addr_o <= `BSOG_BLANK_LO;
                        state <= bsog_pkg::BSOG_ST_REQ;
                    end
                end
                bsog_pkg::BSOG_ST_REQ: begin
                    flash_rd_o <= 1'b1;
                    state <= bsog_pkg::BSOG_ST_WAIT;
                end
                bsog_pkg::BSOG_ST_WAIT: begin
                    if (flash_rvalid_i) begin
                        if (flash_addr_o == `BSOG_BLANK_HI) begin
                            state <= bsog_pkg::BSOG_ST_DECIDE;
                        end else begin
                            flash_addr_o <= flash_addr_o + 16'h0001;
                            state <= bsog_pkg::BSOG_ST_REQ;
                        end
                    end
                end
                bsog_pkg::BSOG_ST_DECIDE: begin
                    if (!next_pass && !cmd.parallel) begin
                        state <= bsog_pkg::BSOG_ST_IDLE;
                    end else begin
                        state <= bsog_pkg::BSOG_ST_READY;
                    end
                end
                bsog_pkg::BSOG_ST_IDLE: state <= bsog_pkg::BSOG_ST_IDLE;
                default: state <= bsog_pkg::BSOG_ST_READY;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            erase_skip <= 8'h00;
            debug_skip <= 8'h00;
            blank <= 1'b0;
        end else if (state == bsog_pkg::BSOG_ST_READY && cmd_wr) begin
            blank <= 1'b1;
        end else if (state == bsog_pkg::BSOG_ST_WAIT && flash_rvalid_i) begin
            if (flash_rdata_i != `BSOG_ERASED) begin
                blank <= 1'b0;
            end
            if (flash_addr_o == `BSOG_ERASE_SKIP_ADDR) begin
                erase_skip <= flash_rdata_i;
            end
            if (flash_addr_o == `BSOG_DEBUG_SKIP_ADDR) begin
                debug_skip <= flash_rdata_i;
            end
        end
    end

    assign is_erase = !cmd.dbg && (cmd.code == `BSOG_CMD_ERASE);

    always_comb begin
        next_pass = 1'b1;
        next_err = bsog_pkg::BSOG_ERR_NONE;
        if (cmd.parallel) begin
            if (!is_erase && sec_en_o) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_LOCKED;
            end
        end else if (cmd.dbg) begin
            if (debug_skip != `BSOG_ERASED && sec_en_o) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_DEBUG;
            end else if (!blank && !cmd.str_ok) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_STRING;
            end
        end else if (is_erase) begin
            if (erase_skip == `BSOG_ERASED && !cmd.whole) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_SECTOR;
            end else if (!cmd.addr_ok) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_ADDR;
            end else if (erase_skip != `BSOG_ERASED && !blank && !cmd.str_ok) begin
                next_pass = 1'b0;
                next_err = bsog_pkg::BSOG_ERR_STRING;
            end
        end else if (!cmd.addr_ok) begin
            next_pass = 1'b0;
            next_err = bsog_pkg::BSOG_ERR_ADDR;
        end else if (!blank && !cmd.str_ok) begin
            next_pass = 1'b0;
            next_err = bsog_pkg::BSOG_ERR_STRING;
        end
    end

    // For a failed serial command the error pulse and the idle level rise together at the verdict edge.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            grant_o <= 1'b0;
            err_o <= 1'b0;
            idle_o <= 1'b0;
            err_code <= bsog_pkg::BSOG_ERR_NONE;
        end else begin
            grant_o <= 1'b0;
            err_o <= 1'b0;
            if (state == bsog_pkg::BSOG_ST_DECIDE) begin
                grant_o <= next_pass;
                err_o <= !next_pass;
                err_code <= next_err;
                idle_o <= !next_pass && !cmd.parallel;
            end
        end
    end

    assign secset_go = state == bsog_pkg::BSOG_ST_DECIDE && next_pass &&
        !cmd.dbg && !cmd.parallel && cmd.code == `BSOG_CMD_SECSET;

    // The stored security state is loaded once after reset is released.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_done <= 1'b0;
            sec_en_o <= 1'b0;
            sec_pending <= 1'b0;
        end else if (!init_done) begin
            init_done <= 1'b1;
            sec_en_o <= sec_nv_i;
        end else begin
            if (state == bsog_pkg::BSOG_ST_DECIDE && next_pass && is_erase && cmd.whole) begin
                sec_en_o <= 1'b0;
            end else if (sec_pending && tmr_done) begin
                sec_en_o <= 1'b1;
            end
            if (secset_go) begin
                sec_pending <= 1'b1;
            end else if (tmr_done) begin
                sec_pending <= 1'b0;
            end
        end
    end

    function automatic logic [20:0] event_delay(input logic [3:0] code,
                                                input logic [20:0] cksum_flash);
        case (bsog_pkg::bsog_event_t'(code))
            bsog_pkg::BSOG_EV_ECHO86: event_delay = `BSOG_T_ECHO86;
            bsog_pkg::BSOG_EV_ECHO79: event_delay = `BSOG_T_ECHO79;
            bsog_pkg::BSOG_EV_ECHOOP: event_delay = `BSOG_T_ECHOOP;
            bsog_pkg::BSOG_EV_CKSUM_FLASH: event_delay = cksum_flash;
            bsog_pkg::BSOG_EV_CKSUM_RAM: event_delay = `BSOG_T_CKSUM_RAM;
            bsog_pkg::BSOG_EV_HEXREC: event_delay = `BSOG_T_HEXREC;
            bsog_pkg::BSOG_EV_READ: event_delay = `BSOG_T_READ;
            bsog_pkg::BSOG_EV_EMU: event_delay = `BSOG_T_EMU;
            default: event_delay = `BSOG_T_ECHOOP;
        endcase
    endfunction

    // Security enable wins over an event write in the same cycle; any start while the timer is busy is dropped.
    always_comb begin
        tmr_start = 1'b0;
        tmr_load = `BSOG_T_SECSET;
        if (secset_go) begin
            tmr_start = 1'b1;
        end else if (evt_wr && !idle_o && !tmr_busy) begin
            tmr_start = 1'b1;
            tmr_load = event_delay(avs_writedata_i[3:0], CKSUM_FLASH_GEAR);
        end
    end

    bsog_gear_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(gear_tick),
        .start_i(tmr_start),
        .load_i(tmr_load),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resp_o <= 1'b0;
        end else begin
            resp_o <= tmr_done && !idle_o;
        end
    end

    sequence s_fail;
        err_o ##0 idle_o;
    endsequence

    sequence s_serial_decide;
        state == bsog_pkg::BSOG_ST_DECIDE && !cmd.parallel;
    endsequence

    property p_idle_has_cause;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(idle_o) |-> s_fail;
    endproperty
    a_idle_has_cause: assert property (p_idle_has_cause)
        else $error("Idle entered without an error pulse.");

    property p_idle_sticky;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        idle_o |=> idle_o && !resp_o && !grant_o;
    endproperty
    a_idle_sticky: assert property (p_idle_sticky)
        else $error("Idle left or spoke before reset.");

    property p_sector_idle;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (s_serial_decide and (is_erase && !cmd.whole && erase_skip == `BSOG_ERASED))
            |=> s_fail;
    endproperty
    a_sector_idle: assert property (p_sector_idle)
        else $error("Sector erase with skip byte set did not idle.");

    property p_debug_locked;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (s_serial_decide and (cmd.dbg && sec_en_o && debug_skip != `BSOG_ERASED))
            |=> s_fail ##1 idle_o;
    endproperty
    a_debug_locked: assert property (p_debug_locked)
        else $error("Debug start under security program not refused.");

    property p_whole_erase_clears;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (state == bsog_pkg::BSOG_ST_DECIDE && is_erase && cmd.whole && next_pass)
            |=> grant_o && !sec_en_o;
    endproperty
    a_whole_erase_clears: assert property (p_whole_erase_clears)
        else $error("Whole-chip erase left the security program on.");

    property p_parallel_erase;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (state == bsog_pkg::BSOG_ST_DECIDE && cmd.parallel && is_erase) |=> grant_o && !idle_o;
    endproperty
    a_parallel_erase: assert property (p_parallel_erase)
        else $error("Parallel erase was not granted.");

    property p_other_needs_string;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (s_serial_decide and (!is_erase && !cmd.dbg && !blank && !cmd.str_ok)) |=> s_fail;
    endproperty
    a_other_needs_string: assert property (p_other_needs_string)
        else $error("Command passed without password string.");

    property p_blank_free;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (s_serial_decide and (!is_erase && !cmd.dbg && blank && cmd.addr_ok)) |=> grant_o;
    endproperty
    a_blank_free: assert property (p_blank_free)
        else $error("Blank device still asked for a password string.");

    property p_erase_skip_string;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (s_serial_decide and (is_erase && cmd.whole && cmd.addr_ok &&
            erase_skip == `BSOG_ERASED)) |=> grant_o ##1 !sec_en_o;
    endproperty
    a_erase_skip_string: assert property (p_erase_skip_string)
        else $error("Erase with skip byte set still checked the string.");

    property p_scan_window;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(state == bsog_pkg::BSOG_ST_DECIDE) |-> $past(flash_addr_o) == `BSOG_BLANK_HI;
    endproperty
    a_scan_window: assert property (p_scan_window)
        else $error("Verdict reached before the option window was read.");
endmodule // bsog_gate

/* File: hw/bsog_gear_timer.sv */
// Down counter of gear clock ticks that pulses when a response is due.
`timescale 1ns/1ps
module bsog_gear_timer (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [20:0] load_i,
    output logic busy_o,
    output logic done_o
);
    logic [20:0] remain;
    logic [20:0] seen;
    logic [20:0] load_q;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            remain <= 21'h000000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                remain <= load_i;
                busy_o <= 1'b1;
            end else if (busy_o && tick_i) begin
                remain <= remain - 21'h000001;
                if (remain == 21'h000001) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    // Helper count of ticks since start, read only by the check below.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen <= 21'h000000;
            load_q <= 21'h000000;
        end else if (start_i && !busy_o) begin
            seen <= 21'h000000;
            load_q <= load_i;
        end else if (busy_o && tick_i) begin
            seen <= seen + 21'h000001;
        end
    end

    property p_done_after_load;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        done_o |-> (seen == load_q);
    endproperty
    a_done_after_load: assert property (p_done_after_load)
        else $error("Response pulse not after the loaded tick count.");
endmodule // bsog_gear_timer

/* File: hw/bsog_map.svh */
// Register offsets, option byte addresses, command codes and timing counts.
`ifndef BSOG_MAP_SVH
`define BSOG_MAP_SVH
`define BSOG_REG_CMD 5'h00
`define BSOG_REG_EVT 5'h04
`define BSOG_REG_STATUS 5'h08
`define BSOG_REG_OPT 5'h0c
`define BSOG_ERASE_SKIP_ADDR 16'hfffa
`define BSOG_DEBUG_SKIP_ADDR 16'hfffb
`define BSOG_BLANK_LO 16'hffe0
`define BSOG_BLANK_HI 16'hffff
`define BSOG_ERASED 8'hff
`define BSOG_CMD_ERASE 8'hf0
`define BSOG_CMD_SECSET 8'hfa
`define BSOG_CORE_MHZ 50
`define BSOG_GEAR_MHZ 10
`define BSOG_T_ECHO86 21'h000294
`define BSOG_T_ECHO79 21'h00021c
`define BSOG_T_ECHOOP 21'h00012c
`define BSOG_T_CKSUM_FLASH 1493340
`define BSOG_T_CKSUM_RAM 21'h0000a0
`define BSOG_T_HEXREC 21'h0000c8
`define BSOG_T_READ 21'h0001ae
`define BSOG_T_EMU 21'h0001a4
`define BSOG_T_SECSET 21'h000438
`endif

/* File: hw/bsog_pkg.sv */
// Types shared by the boot security option gate.
package bsog_pkg;
    typedef enum logic [2:0] {
        BSOG_ST_READY = 3'b000,
        BSOG_ST_REQ = 3'b001,
        BSOG_ST_WAIT = 3'b010,
        BSOG_ST_DECIDE = 3'b011,
        BSOG_ST_IDLE = 3'b100
    } bsog_state_t;
    typedef enum logic [2:0] {
        BSOG_ERR_NONE = 3'b000,
        BSOG_ERR_SECTOR = 3'b001,
        BSOG_ERR_ADDR = 3'b010,
        BSOG_ERR_STRING = 3'b011,
        BSOG_ERR_DEBUG = 3'b100,
        BSOG_ERR_LOCKED = 3'b101
    } bsog_err_t;
    typedef enum logic [3:0] {
        BSOG_EV_ECHO86 = 4'h0,
        BSOG_EV_ECHO79 = 4'h1,
        BSOG_EV_ECHOOP = 4'h2,
        BSOG_EV_CKSUM_FLASH = 4'h3,
        BSOG_EV_CKSUM_RAM = 4'h4,
        BSOG_EV_HEXREC = 4'h5,
        BSOG_EV_READ = 4'h6,
        BSOG_EV_EMU = 4'h7
    } bsog_event_t;
    typedef struct packed {
        logic dbg;
        logic parallel;
        logic addr_ok;
        logic str_ok;
        logic whole;
        logic [7:0] code;
    } bsog_cmd_t;
endpackage

/* File: verification/boot_security_option_gate_bench.sv */
// Self-checking bench for the boot security option gate.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module boot_security_option_gate_bench;
    logic core_clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, sec_nv = 1'b0;
    logic slow = 1'b0, blank = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0] be = 4'hf;
    logic [7:0] skip_e = 8'h00, skip_d = 8'h00, f_rdata;
    logic waitreq, f_rd, f_rvalid, grant, err, resp, idle, sec_en, in_range;
    logic [15:0] f_addr;
    int bad_count = 0, samples_checked = 0, cyc = 0, n;
    int ev_ticks[8] = '{660, 540, 300, 20, 160, 200, 430, 420};

    always #10 core_clk = ~core_clk;

    bsog_gate #(.CKSUM_FLASH_GEAR(21'h000014)) dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .flash_addr_o(f_addr), .flash_rd_o(f_rd), .flash_rdata_i(f_rdata),
        .flash_rvalid_i(f_rvalid), .sec_nv_i(sec_nv), .grant_o(grant), .err_o(err),
        .resp_o(resp), .idle_o(idle), .sec_en_o(sec_en));
    bsog_flash_model flash_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .flash_addr_i(f_addr),
        .flash_rd_i(f_rd), .slow_i(slow), .blank_i(blank), .erase_skip_i(skip_e),
        .debug_skip_i(skip_d), .flash_rdata_o(f_rdata), .flash_rvalid_o(f_rvalid));

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do @(posedge core_clk); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic do_reset(input logic nv, input logic [7:0] se, input logic [7:0] sd);
        sec_nv <= nv;
        skip_e <= se;
        skip_d <= sd;
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        `CHK(waitreq, 1'b1);
    endtask

    // Issues a command and checks its verdict, idle level and recorded cause.
    task automatic cmd(input bsog_pkg::bsog_cmd_t c, input logic g, input logic [2:0] code,
                       input logic idl);
        bus(1'b1, 5'h00, {19'h0, c});
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((grant | err) !== 1'b1 && n < 600);
        `CHK({grant, err, idle}, {g, !g, idl});
        bus(1'b0, 5'h08, 32'h0);
        `CHK({q[7:5], q[0]}, {code, idl});
    endtask

    initial begin
        do_reset(1'b1, 8'hff, 8'h00);
        // The stored security state is loaded at the first edge after release.
        repeat (2) @(posedge core_clk);
        `CHK(sec_en, 1'b1);
        cmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'hf0}, 1'b1, 3'h0, 1'b0);
        `CHK(sec_en, 1'b0);
        bus(1'b0, 5'h0c, 32'h0);
        `CHK(q[15:0], 16'h00ff);
        bus(1'b0, 5'h10, 32'h0);
        `CHK(q, 32'h0);
        do_reset(1'b0, 8'h00, 8'h00);
        slow <= 1'b1;
        cmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'hf0}, 1'b0, 3'h3, 1'b1);
        bus(1'b1, 5'h04, 32'h2);
        n = 0;
        repeat (1600) begin
            @(posedge core_clk);
            n += (resp !== 1'b0);
        end
        `CHK(n, 0);
        slow <= 1'b0;
        do_reset(1'b0, 8'hff, 8'h00);
        cmd('{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'hf0}, 1'b0, 3'h1, 1'b1);
        do_reset(1'b0, 8'hff, 8'hff);
        cmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h40}, 1'b0, 3'h3, 1'b1);
        do_reset(1'b1, 8'h00, 8'hff);
        cmd('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, 1'b1, 3'h0, 1'b0);
        do_reset(1'b1, 8'h00, 8'hff);
        cmd('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}, 1'b0, 3'h3, 1'b1);
        do_reset(1'b0, 8'h00, 8'h00);
        cmd('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, 1'b1, 3'h0, 1'b0);
        do_reset(1'b1, 8'h00, 8'h00);
        cmd('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, 1'b0, 3'h4, 1'b1);
        do_reset(1'b1, 8'h00, 8'h00);
        cmd('{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'hf0}, 1'b1, 3'h0, 1'b0);
        repeat (5500) @(posedge core_clk);
        cmd('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00}, 1'b1, 3'h0, 1'b0);
        do_reset(1'b1, 8'h00, 8'h00);
        cmd('{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'hf0}, 1'b1, 3'h0, 1'b0);
        do_reset(1'b0, 8'h00, 8'h00);
        cmd('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h40}, 1'b1, 3'h0, 1'b0);
        do_reset(1'b1, 8'h00, 8'h00);
        cmd('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h40}, 1'b0, 3'h5, 1'b0);
        blank <= 1'b1;
        do_reset(1'b1, 8'hff, 8'hff);
        cmd('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}, 1'b1, 3'h0, 1'b0);
        `CHK(q[4], 1'b1);
        cmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h40}, 1'b1, 3'h0, 1'b0);
        blank <= 1'b0;
        do_reset(1'b0, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 5'h04, 32'(i));
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (resp !== 1'b1 && n < 4000);
            in_range = n >= 5 * ev_ticks[i] - 4 && n <= 5 * ev_ticks[i] + 8;
            `CHK(in_range, 1'b1);
            repeat (5 * 270) @(posedge core_clk);
        end
        cmd('{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'hfa}, 1'b1, 3'h0, 1'b0);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (resp !== 1'b1 && n < 6000);
        `CHK(n >= 5380 && n <= 5420, 1'b1);
        @(posedge core_clk);
        `CHK(sec_en, 1'b1);
        complete_run();
    end
endmodule // boot_security_option_gate_bench

/* File: verification/bsog_flash_model.sv */
// Behavioural option window of the flash array answering the gate's byte reads.
`timescale 1ns/1ps
module bsog_flash_model (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] flash_addr_i,
    input wire logic flash_rd_i,
    input wire logic slow_i,
    input wire logic blank_i,
    input wire logic [7:0] erase_skip_i,
    input wire logic [7:0] debug_skip_i,
    output logic [7:0] flash_rdata_o,
    output logic flash_rvalid_o
);
    logic pend;
    logic [1:0] cnt;
    logic [15:0] addr;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        if (a == 16'hfffa) return erase_skip_i;
        if (a == 16'hfffb) return debug_skip_i;
        if (a == 16'hffe0) return blank_i ? 8'hff : 8'h00;
        return 8'hff;
    endfunction

    // Outside a valid cycle the data toggles so a stale byte is never mistaken for an answer.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend <= 1'b0;
            cnt <= 2'h0;
            addr <= 16'h0000;
            flash_rvalid_o <= 1'b0;
            flash_rdata_o <= 8'h00;
        end else begin
            flash_rvalid_o <= 1'b0;
            flash_rdata_o <= ~flash_rdata_o;
            if (flash_rd_i) begin
                pend <= 1'b1;
                addr <= flash_addr_i;
                cnt <= slow_i ? 2'h3 : 2'h0;
            end else if (pend && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (pend) begin
                pend <= 1'b0;
                flash_rvalid_o <= 1'b1;
                flash_rdata_o <= byte_at(addr);
            end
        end
    end
endmodule // bsog_flash_model
